// [core/mudb_defs.vh]
`ifndef MUDB_DEFS_VH
`define MUDB_DEFS_VH
`define MUDB_REG_CTRL 8'h00
`define MUDB_REG_DELAY 8'h04
`define MUDB_REG_USED 8'h08
`define MUDB_REG_FAIL 8'h0c
`define MUDB_REG_VEND 8'h10
`define MUDB_REG_STAT1 8'h14
`define MUDB_REG_STAT2 8'h18
`define MUDB_REG_COUNT 8'h1c
`define MUDB_REG_SAMPLE 8'h20
`define MUDB_CTRL_MAINT 0
`define MUDB_CTRL_TEST 1
`define MUDB_CTRL_WAKE 2
`define MUDB_CTRL_INTERP 3
`define MUDB_CTRL_DERIV 4
`define MUDB_CTRL_RANGE 5
`define MUDB_CTRL_SYNCEN 6
`define MUDB_CTRL_RST 32'h0000_0000
`define MUDB_DELAY_RST 16'h0000
`define MUDB_USED_RST 12'hfff
`define MUDB_SW1_MAINT 0
`define MUDB_SW1_TEST 1
`define MUDB_SW1_WAKE 2
`define MUDB_SW1_INTERP 3
`define MUDB_SW1_SYNCLOST 4
`define MUDB_SW1_CH1 5
`define MUDB_SW1_DERIV 12
`define MUDB_SW1_RANGE 13
`define MUDB_POS_SAT 16'h7fff
`define MUDB_NEG_SAT 16'h8000
`define MUDB_ZERO 16'h0000
`define MUDB_CH_NEUT_I 3
`define MUDB_CH_NEUT_V 10
`endif

// [core/mudb_chan_sat.v]
`timescale 1ns/1ps
`include "mudb_defs.vh"
module mudb_chan_sat #(
  parameter IN_W = 24
) (
  input wire [IN_W-1:0] i_raw,
  input wire i_force_ovf,
  input wire i_used,
  output reg [15:0] o_word,
  output reg o_ovf
);
  wire neg = i_raw[IN_W-1];
  wire [IN_W-16:0] top = i_raw[IN_W-1:15];
  wire fits = (&top) | ~(|top);
  always @*
  begin
    o_ovf = ~fits | i_force_ovf;
    if (!i_used)
      o_word = `MUDB_ZERO;
    else if (o_ovf)
      o_word = neg ? `MUDB_NEG_SAT : `MUDB_POS_SAT;
    else
      o_word = i_raw[15:0];
  end
endmodule // mudb_chan_sat

// [core/mudb_builder.v]
// Overview of operation
// - rated delay is unsigned 16-bit microseconds
// - twelve channels, signed 16-bit linear words
// - overflow saturates to 7fff or 8000
// - summed neutral current overflows with any phase
// - summed neutral voltage overflows with any phase
// - neutral current always uses metering scale
// - 16-bit sequence count increments per frame
// - sequence count wraps to zero
// - sync pulse clears sequence count
// - frame sampled at sync gets count zero
// - unused channel invalid and word zero
// - transducer failure sets invalid, and maintenance if the channel is used
// - maintenance may be set preventively
// - wake-up sets invalid flags and wake flag
// - sync lost needs missing sync and drift
// - status one bits zero to three
// - interpolation use also sets bit four
// - status one bits five-eleven channels one-seven
// - bit twelve marks derivative current output
// - bit thirteen selects protection current scale
// - status two bits zero-four channels eight-twelve
`timescale 1ns/1ps
`include "mudb_defs.vh"
module mudb_builder #(
  parameter NCH = 12,
  parameter IN_W = 24
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output reg o_hreadyout,
  output reg o_hresp,
  input wire [NCH*IN_W-1:0] i_sample_raw,
  input wire i_sample_strobe,
  input wire i_sync_pulse,
  input wire i_sync_valid,
  input wire i_clock_drift,
  input wire i_neut_i_summed,
  input wire i_neut_v_summed,
  output reg o_frame_valid,
  output reg [NCH*16-1:0] o_sample_words,
  output reg [15:0] o_sample_sequence_count,
  output reg [15:0] o_first_status_word,
  output reg [15:0] o_second_status_word,
  output reg [15:0] o_rated_delay_field,
  output reg o_neut_scale_metering
);
  // pin synchronisers
  reg [1:0] strb_sync_reg;
  reg [1:0] sync_sync_reg;
  reg [1:0] sval_sync_reg;
  reg [1:0] drift_sync_reg;
  reg strb_last_reg;
  reg sync_last_reg;
  reg [NCH*IN_W-1:0] raw_meta_reg;
  reg [NCH*IN_W-1:0] raw_sync_reg;
  reg [1:0] neut_i_sync_reg;
  reg [1:0] neut_v_sync_reg;
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      strb_sync_reg <= 2'h0;
      sync_sync_reg <= 2'h0;
      sval_sync_reg <= 2'h0;
      drift_sync_reg <= 2'h0;
      strb_last_reg <= 1'b0;
      sync_last_reg <= 1'b0;
      raw_meta_reg <= {(NCH*IN_W){1'b0}};
      raw_sync_reg <= {(NCH*IN_W){1'b0}};
      neut_i_sync_reg <= 2'h0;
      neut_v_sync_reg <= 2'h0;
    end
    else
    begin
      strb_sync_reg <= {strb_sync_reg[0], i_sample_strobe};
      sync_sync_reg <= {sync_sync_reg[0], i_sync_pulse};
      sval_sync_reg <= {sval_sync_reg[0], i_sync_valid};
      drift_sync_reg <= {drift_sync_reg[0], i_clock_drift};
      strb_last_reg <= strb_sync_reg[1];
      sync_last_reg <= sync_sync_reg[1];
      raw_meta_reg <= i_sample_raw;
      raw_sync_reg <= raw_meta_reg;
      neut_i_sync_reg <= {neut_i_sync_reg[0], i_neut_i_summed};
      neut_v_sync_reg <= {neut_v_sync_reg[0], i_neut_v_summed};
    end
  end
  wire strobe_rise = strb_sync_reg[1] & ~strb_last_reg;
  wire sync_rise = sync_sync_reg[1] & ~sync_last_reg;

  // ahb-lite slave
  reg [31:0] ctrl_reg;
  reg [15:0] delay_reg;
  reg [NCH-1:0] used_reg;
  reg [NCH-1:0] fail_reg;
  reg [7:0] vend_reg;
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  reg [15:0] seq_reg;
  wire addr_phase = i_hsel & i_hready & i_htrans[1];
  wire [7:0] a = i_haddr[7:0];
  wire sync_en = ctrl_reg[`MUDB_CTRL_SYNCEN];
  wire [4:0] samp_idx = a[6:2] - 5'h08;
  wire [15:0] sw1_w;
  wire [15:0] sw2_w;
  wire [NCH*16-1:0] words_w;
  reg [31:0] rd_next;
  always @*
  begin
    rd_next = 32'h0000_0000;
    case (a)
      `MUDB_REG_CTRL: rd_next = ctrl_reg;
      `MUDB_REG_DELAY: rd_next = {16'h0000, delay_reg};
      `MUDB_REG_USED: rd_next = {{(32-NCH){1'b0}}, used_reg};
      `MUDB_REG_FAIL: rd_next = {{(32-NCH){1'b0}}, fail_reg};
      `MUDB_REG_VEND: rd_next = {24'h000000, vend_reg};
      `MUDB_REG_STAT1: rd_next = {16'h0000, o_first_status_word};
      `MUDB_REG_STAT2: rd_next = {16'h0000, o_second_status_word};
      `MUDB_REG_COUNT: rd_next = {16'h0000, o_sample_sequence_count};
      default:
      begin
        if (a >= `MUDB_REG_SAMPLE && samp_idx < NCH && a[1:0] == 2'h0 && !a[7])
          rd_next = {16'h0000, o_sample_words[samp_idx*16 +: 16]};
      end
    endcase
  end
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_hrdata <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      ctrl_reg <= `MUDB_CTRL_RST;
      delay_reg <= `MUDB_DELAY_RST;
      used_reg <= {NCH{1'b1}};
      fail_reg <= {NCH{1'b0}};
      vend_reg <= 8'h00;
    end
    else
    begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      wr_pend_reg <= addr_phase & i_hwrite;
      if (addr_phase)
        wr_addr_reg <= a;
      if (addr_phase && !i_hwrite)
        o_hrdata <= rd_next;
      if (wr_pend_reg)
      begin
        case (wr_addr_reg)
          `MUDB_REG_CTRL: ctrl_reg <= {25'h0000000, i_hwdata[6:0]};
          `MUDB_REG_DELAY: delay_reg <= i_hwdata[15:0];
          `MUDB_REG_USED: used_reg <= i_hwdata[NCH-1:0];
          `MUDB_REG_FAIL: fail_reg <= i_hwdata[NCH-1:0];
          `MUDB_REG_VEND: vend_reg <= i_hwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // per-channel saturation and validity
  wire [NCH-1:0] ovf_w;
  wire [NCH-1:0] inval;
  wire wake = ctrl_reg[`MUDB_CTRL_WAKE];
  wire phase_i_ovf = |ovf_w[2:0];
  wire phase_v_ovf = |ovf_w[9:7];
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
      wire force_w;
      if (g == `MUDB_CH_NEUT_I)
      begin : g_ni
        assign force_w = neut_i_sync_reg[1] & phase_i_ovf;
      end
      else if (g == `MUDB_CH_NEUT_V)
      begin : g_nv
        assign force_w = neut_v_sync_reg[1] & phase_v_ovf;
      end
      else
      begin : g_pl
        assign force_w = 1'b0;
      end
      mudb_chan_sat #(
        .IN_W(IN_W)
      ) u_sat (
        .i_raw(raw_sync_reg[g*IN_W +: IN_W]),
        .i_force_ovf(force_w),
        .i_used(used_reg[g]),
        .o_word(words_w[g*16 +: 16]),
        .o_ovf(ovf_w[g])
      );
      assign inval[g] = ~used_reg[g] | fail_reg[g] | wake;
      if (g < 7)
      begin : g_s1
        assign sw1_w[`MUDB_SW1_CH1 + g] = inval[g];
      end
      else
      begin : g_s2
        assign sw2_w[g - 7] = inval[g];
      end
    end
  endgenerate

  // validity and status words
  wire maint = ctrl_reg[`MUDB_CTRL_MAINT] | (|(fail_reg & used_reg));
  wire interp = ctrl_reg[`MUDB_CTRL_INTERP];
  wire sync_lost = ~sval_sync_reg[1] & drift_sync_reg[1];
  assign sw1_w[`MUDB_SW1_MAINT] = maint;
  assign sw1_w[`MUDB_SW1_TEST] = ctrl_reg[`MUDB_CTRL_TEST];
  assign sw1_w[`MUDB_SW1_WAKE] = wake;
  assign sw1_w[`MUDB_SW1_INTERP] = interp;
  assign sw1_w[`MUDB_SW1_SYNCLOST] = sync_lost | interp;
  assign sw1_w[`MUDB_SW1_DERIV] = ctrl_reg[`MUDB_CTRL_DERIV];
  assign sw1_w[`MUDB_SW1_RANGE] = ctrl_reg[`MUDB_CTRL_RANGE];
  assign sw1_w[15:14] = 2'h0;
  assign sw2_w[15:8] = vend_reg;
  assign sw2_w[7:5] = 3'h0;

  // sync arming: a sync seen before its frame zeroes that frame's count
  localparam SYNC_IDLE = 2'h1;
  localparam SYNC_ARMED = 2'h2;
  reg [1:0] sync_state_reg;
  reg [1:0] sync_state_next;
  always @*
  begin
    sync_state_next = sync_state_reg;
    case (sync_state_reg)
      SYNC_IDLE:
      begin
        if (sync_en && sync_rise && !strobe_rise)
          sync_state_next = SYNC_ARMED;
      end
      SYNC_ARMED:
      begin
        if (strobe_rise || !sync_en)
          sync_state_next = SYNC_IDLE;
      end
      default:
      begin
        sync_state_next = SYNC_IDLE;
      end
    endcase
  end
  wire sync_armed = (sync_state_reg == SYNC_ARMED);

  // frame assembly and sequence count
  wire [15:0] seq_use = (sync_en && (sync_rise || sync_armed)) ? 16'h0000 : seq_reg;
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      seq_reg <= 16'h0000;
      sync_state_reg <= SYNC_IDLE;
      o_frame_valid <= 1'b0;
      o_sample_words <= {(NCH*16){1'b0}};
      o_sample_sequence_count <= 16'h0000;
      o_first_status_word <= 16'h0000;
      o_second_status_word <= 16'h0000;
      o_rated_delay_field <= 16'h0000;
      o_neut_scale_metering <= 1'b1;
    end
    else
    begin
      o_frame_valid <= strobe_rise;
      sync_state_reg <= sync_state_next;
      o_neut_scale_metering <= 1'b1;
      o_rated_delay_field <= delay_reg;
      if (strobe_rise)
      begin
        o_sample_words <= words_w;
        o_sample_sequence_count <= seq_use;
        seq_reg <= seq_use + 16'h0001;
        o_first_status_word <= sw1_w;
        o_second_status_word <= sw2_w;
      end
    end
  end
endmodule // mudb_builder

// [tb/mudb_builder_assertions.sv]
`timescale 1ns/1ps
module mudb_chk #(
  parameter NCH = 12,
  parameter IN_W = 24
) (
  input wire i_clk,
  input wire i_resetn,
  input wire [NCH*IN_W-1:0] i_sample_raw,
  input wire i_sync_valid,
  input wire i_clock_drift,
  input wire o_frame_valid,
  input wire [NCH*16-1:0] o_sample_words,
  input wire [15:0] o_sample_sequence_count,
  input wire [15:0] o_first_status_word,
  input wire [15:0] o_second_status_word,
  input wire o_neut_scale_metering
);
  wire signed [IN_W-1:0] raw1 = i_sample_raw[IN_W-1:0];
  wire [15:0] sat1 = (raw1 > 32767) ? 16'h7fff : (raw1 < -32768) ? 16'h8000 : raw1[15:0];
  wire lost = !i_sync_valid && i_clock_drift;
  wire fv = o_frame_valid;
  wire [15:0] cnt = o_sample_sequence_count;
  wire [15:0] sw1 = o_first_status_word;
  wire [15:0] sw2 = o_second_status_word;
  reg [15:0] last_reg;
  always @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
      last_reg <= 16'h0000;
    else if (fv)
      last_reg <= cnt;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  a_pulse_one: assert property (fv |=> !fv) else $error("long pulse");
  a_count_step: assert property (fv |-> cnt == last_reg + 16'h0001 || cnt == 16'h0000)
    else $error("count skipped");
  a_count_hold: assert property (!fv |-> $stable(cnt)) else $error("count moved");
  a_reserved_zero: assert property (sw1[15:14] == 2'h0 && sw2[7:5] == 3'h0)
    else $error("reserved set");
  a_neut_scale: assert property (o_neut_scale_metering) else $error("neutral scale");
  a_sync_lost: assert property (fv && !sw1[3] |-> sw1[4] == $past(lost, 3))
    else $error("sync lost bit");
  a_interp_four: assert property (fv && sw1[3] |-> sw1[4]) else $error("interp bit");
  a_wake_invalid: assert property (fv && sw1[2] |-> sw1[11:5] == 7'h7f && sw2[4:0] == 5'h1f)
    else $error("wake flags");
  a_sat_chan: assert property (fv && !sw1[5] |-> o_sample_words[15:0] == $past(sat1, 3))
    else $error("saturation");
  c_sync_zero: cover property (fv && cnt == 16'h0000);
  c_lost: cover property (fv && sw1[4] && !sw1[3]);
  c_wake: cover property (fv && sw1[2]);
endmodule // mudb_chk
bind mudb_builder mudb_chk #(.NCH(NCH), .IN_W(IN_W)) u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_sample_raw(i_sample_raw), .i_sync_valid(i_sync_valid), .i_clock_drift(i_clock_drift),
  .o_frame_valid(o_frame_valid), .o_sample_words(o_sample_words),
  .o_sample_sequence_count(o_sample_sequence_count), .o_first_status_word(o_first_status_word),
  .o_second_status_word(o_second_status_word), .o_neut_scale_metering(o_neut_scale_metering));

// [tb/mudb_rx_model.sv]
`timescale 1ns/1ps
module mudb_rx_model (
  input wire i_clk,
  input wire i_resetn,
  input wire i_frame_valid,
  input wire [15:0] i_count,
  output reg [15:0] o_count,
  output reg [15:0] o_frames
);
  // receiver takes each frame on its one-cycle valid pulse
  always @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      o_count <= 16'h0000;
      o_frames <= 16'h0000;
    end
    else if (i_frame_valid)
    begin
      o_count <= i_count;
      o_frames <= o_frames + 16'h0001;
    end
endmodule // mudb_rx_model

// [tb/test_mudb_builder.sv]
`timescale 1ns/1ps
`include "mudb_defs.vh"
module test_mudb_builder;
  reg i_clk = 1'b0, i_resetn = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0;
  reg [31:0] i_haddr = 32'h0, i_hwdata = 32'h0;
  reg [1:0] i_htrans = 2'h0;
  reg [2:0] i_hsize = 3'h0;
  reg [287:0] i_sample_raw = 288'h0;
  reg i_sample_strobe = 1'b0, i_sync_pulse = 1'b0, i_sync_valid = 1'b1, i_clock_drift = 1'b0;
  reg i_neut_i_summed = 1'b0, i_neut_v_summed = 1'b0;
  wire [31:0] o_hrdata;
  wire o_hreadyout, o_hresp, o_frame_valid, o_neut_scale_metering;
  wire [191:0] w;
  wire [15:0] o_cnt, sw1, sw2, o_dly, rx_cnt, rx_n;
  reg [31:0] rd;
  reg [15:0] n0;
  integer n_fail = 0, comparisons = 0, cyc = 0;
  always #10 i_clk = ~i_clk;
  mudb_builder dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_sample_raw(i_sample_raw), .i_sample_strobe(i_sample_strobe), .i_sync_pulse(i_sync_pulse),
    .i_sync_valid(i_sync_valid), .i_clock_drift(i_clock_drift),
    .i_neut_i_summed(i_neut_i_summed), .i_neut_v_summed(i_neut_v_summed),
    .o_frame_valid(o_frame_valid), .o_sample_words(w), .o_sample_sequence_count(o_cnt),
    .o_first_status_word(sw1), .o_second_status_word(sw2), .o_rated_delay_field(o_dly),
    .o_neut_scale_metering(o_neut_scale_metering));
  mudb_rx_model rx (.i_clk(i_clk), .i_resetn(i_resetn), .i_frame_valid(o_frame_valid),
    .i_count(o_cnt), .o_count(rx_cnt), .o_frames(rx_n));
  task summarize;
  begin
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  always @(posedge i_clk)
  begin
    cyc = cyc + 1;
    if (cyc > 3000)
    begin
      n_fail = n_fail + 1;
      summarize;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task bus(input wr, input [31:0] a, input [31:0] d);
  begin
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= a;
    i_hwrite <= wr;
    i_hsize <= 3'h2;
    @(posedge i_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_clk);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    @(posedge i_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_clk);
    rd = o_hrdata;
    chk(o_hresp, 32'h0);
  end
  endtask
  task frame;
  begin
    n0 = rx_n;
    i_sample_strobe <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_sample_strobe <= 1'b0;
    i_sync_pulse <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk(rx_n, n0 + 16'h1);
  end
  endtask
  task t_bus;
  begin
    bus(1'b0, `MUDB_REG_USED, 32'h0);
    chk(rd, 32'h00000fff);
    bus(1'b1, `MUDB_REG_DELAY, 32'h0000ffff);
    bus(1'b0, `MUDB_REG_DELAY, 32'h0);
    chk(rd, 32'h0000ffff);
    chk(o_dly, 32'h0000ffff);
    bus(1'b0, 32'h00000040, 32'h0);
    chk(rd, 32'h0);
  end
  endtask
  task t_words;
  begin
    i_neut_i_summed <= 1'b1;
    i_neut_v_summed <= 1'b1;
    i_sample_raw <= {24'h0, 24'h000010, 48'h0, 24'h010000, 24'h0, 24'hff8000, 24'h0,
      24'h000010, 24'h007fff, 24'hff0000, 24'h010000};
    frame;
    chk(w[15:0], 32'h7fff);
    chk(w[31:16], 32'h8000);
    chk(w[47:32], 32'h7fff);
    chk(w[95:80], 32'h8000);
    chk(w[63:48], 32'h7fff);
    chk(w[175:160], 32'h7fff);
    chk(o_neut_scale_metering, 32'h1);
    bus(1'b0, `MUDB_REG_SAMPLE, 32'h0);
    chk(rd, 32'h00007fff);
  end
  endtask
  task t_count;
  begin
    bus(1'b1, `MUDB_REG_CTRL, 32'h00000040);
    i_sync_pulse <= 1'b1;
    frame;
    chk(rx_cnt, 32'h0);
    frame;
    chk(rx_cnt, 32'h1);
    i_sync_pulse <= 1'b1;
    repeat (4) @(posedge i_clk);
    frame;
    chk(rx_cnt, 32'h0);
    bus(1'b0, `MUDB_REG_COUNT, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `MUDB_REG_CTRL, 32'h00000000);
    i_sync_pulse <= 1'b1;
    frame;
    chk(rx_cnt, 32'h1);
  end
  endtask
  task t_status;
  begin
    bus(1'b1, `MUDB_REG_USED, 32'h00000ffe);
    bus(1'b1, `MUDB_REG_FAIL, 32'h00000800);
    bus(1'b1, `MUDB_REG_VEND, 32'h000000a5);
    bus(1'b1, `MUDB_REG_CTRL, 32'h00000032);
    frame;
    chk(sw1, 32'h3023);
    chk(sw2, 32'ha510);
    chk(w[15:0], 32'h0);
    bus(1'b0, `MUDB_REG_STAT1, 32'h0);
    chk(rd, 32'h00003023);
    bus(1'b0, `MUDB_REG_STAT2, 32'h0);
    chk(rd, 32'h0000a510);
    bus(1'b1, `MUDB_REG_USED, 32'h00000fff);
    bus(1'b1, `MUDB_REG_FAIL, 32'h0);
    bus(1'b1, `MUDB_REG_CTRL, 32'h0000000c);
    frame;
    chk(sw1, 32'h0ffc);
    chk(sw2, 32'ha51f);
    bus(1'b1, `MUDB_REG_CTRL, 32'h00000001);
    i_sync_valid <= 1'b0;
    i_clock_drift <= 1'b1;
    frame;
    chk(sw1, 32'h0011);
    i_clock_drift <= 1'b0;
    frame;
    chk(sw1, 32'h0001);
  end
  endtask
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    t_bus;
    t_words;
    t_count;
    t_status;
    summarize;
  end
endmodule // test_mudb_builder
